// [logic/tmr_status_pkg.sv]
package tmr_status_pkg;

	// ************************************************************
	// Widths and counts
	// ************************************************************
	localparam int WORD_W         = 16;              // Housekeeping and info word width
	localparam int NUM_SLICE      = 3;               // Slices, one per fault region
	localparam int NUM_INFO       = 11;              // Information channels
	localparam int NUM_HK_ERR     = 3;               // Trailing diagnostic error code words

	// ************************************************************
	// Register map (byte addresses)
	// ************************************************************
	localparam logic [7:0] ADDR_CTRL    = 8'h00;     // Control: changeover, primary position
	localparam logic [7:0] ADDR_STATUS  = 8'h04;     // Sticky event status (read only)
	localparam logic [7:0] ADDR_CLEAR   = 8'h08;     // Event clear (write only)
	localparam logic [7:0] ADDR_ENABLE  = 8'h0C;     // Event interrupt enable
	localparam logic [7:0] ADDR_STAMP   = 8'h10;     // Time stamp of last change of state
	localparam logic [7:0] ADDR_INFO0   = 8'h40;     // First of the information channels
	localparam logic [7:0] ADDR_HKERR0  = 8'h80;     // First diagnostic error code word

	// Control register fields
	localparam int CTRL_SWAP_BIT  = 0;               // Active/standby changeover request level
	localparam int CTRL_PCH_LSB   = 8;               // Primary chassis number
	localparam int CTRL_PSL_LSB   = 16;              // Primary slot number

	// Event bits
	localparam int EV_OUT_BIT     = 0;               // Output data changed state
	localparam int EV_FLT_BIT     = 1;               // Line-fault data changed state
	localparam int EV_SWAP_BIT    = 2;               // Changeover happened
	localparam int NUM_EV         = 3;

	// ************************************************************
	// Mode codes
	// ************************************************************
	localparam logic [2:0] MODE_UNKNOWN  = 3'h0;
	localparam logic [2:0] MODE_CONFIG   = 3'h1;
	localparam logic [2:0] MODE_STANDBY  = 3'h2;
	localparam logic [2:0] MODE_ACTIVE   = 3'h3;
	localparam logic [2:0] MODE_MAINTAIN = 3'h4;
	localparam logic [2:0] MODE_SHUTDOWN = 3'h5;
	localparam logic [2:0] MODE_FATAL    = 3'h6;    // Internal only, shown on LEDs

	// Indicator colours
	typedef enum logic [1:0] {
		LED_OFF   = 2'b00,
		LED_GREEN = 2'b01,
		LED_RED   = 2'b10,
		LED_AMBER = 2'b11
	} led_colour_t;

	// Slice health states
	typedef enum logic [1:0] {
		SL_STARTUP = 2'b00,
		SL_HEALTHY = 2'b01,
		SL_FAULT   = 2'b10,
		SL_FATAL   = 2'b11
	} slice_state_t;

	// One module position as seen by a slice
	typedef struct packed {
		logic        present;     // Module fitted
		logic [7:0]  chassis;     // Chassis number
		logic [7:0]  slot;        // Slot number
		logic        healthy;     // No fault detected
		logic [2:0]  mode;        // Mode code
		logic [2:0]  regionOk;    // Fault region C,B,A health
		logic        ejectOpen;   // Ejector open
		logic        simEnable;   // Simulation enabled in configuration
		logic        educated;    // Education complete
		logic        recognized;  // Known by the processor
	} module_pos_t;

	// Timing: flash half period and amber mix divider
	localparam int FLASH_MS       = 250;            // Flash half period in ms
	localparam int CLK_KHZ        = 50000;          // Module clock in kHz
	localparam int FLASH_CYC      = FLASH_MS * CLK_KHZ;
	localparam int AMBER_DIV_W    = 2;              // Amber mix divider width

endpackage

// [logic/tmr_module_status_reporter.sv]
// The AHB-Lite interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps

module tmr_module_status_reporter
	import tmr_status_pkg::*;
#(
	parameter int FLASH_CYCLES = FLASH_CYC,        // Flash half period in clocks
	parameter int OUT_W        = 40                // Output channels watched
)(
	input  wire logic                     sys_clk,
	input  wire logic                     rstn,
	// AHB-Lite slave
	input  wire logic                     hsel,
	input  wire logic [31:0]              haddr,
	input  wire logic [1:0]               htrans,
	input  wire logic                     hwrite,
	input  wire logic [2:0]               hsize,
	input  wire logic [31:0]              hwdata,
	input  wire logic                     hready,
	output logic      [31:0]              hrdata,
	output logic                          hreadyout,
	output logic                          hresp,
	// Slice side (pins from other logic, asynchronous)
	input  wire slice_state_t [NUM_SLICE-1:0] sliceState,
	input  wire logic [NUM_SLICE-1:0][WORD_W-1:0] sliceErrCode,
	input  wire module_pos_t [NUM_SLICE-1:0] primPos,
	input  wire module_pos_t [NUM_SLICE-1:0] secPos,
	input  wire logic [NUM_SLICE-1:0]    swapInProgress,
	input  wire logic [OUT_W-1:0]         outState,
	input  wire logic [OUT_W-1:0]         lineFault,
	// Indicators and interrupt
	output led_colour_t [NUM_SLICE-1:0]  ledHealthy,
	output led_colour_t                   ledActive,
	output led_colour_t                   ledStandby,
	output led_colour_t                   ledEducated,
	output logic                          irq
);

	// ************************************************************
	// Parameter checks
	// ************************************************************
	// Refuse values the divider and change detectors cannot serve
	if (FLASH_CYCLES < 2) begin : g_bad_flash
		$error("FLASH_CYCLES too small");
	end
	if (OUT_W < 1) begin : g_bad_out
		$error("OUT_W must be positive");
	end

	// ************************************************************
	// Input synchronisers
	// ************************************************************
	localparam int SYN_W = 2*NUM_SLICE + NUM_SLICE*WORD_W + 2*NUM_SLICE*$bits(module_pos_t) + NUM_SLICE + 2*OUT_W;
	logic [SYN_W-1:0] syn1_r;                      // First stage, read only by second
	logic [SYN_W-1:0] syn2_r;                      // Second stage
	slice_state_t [NUM_SLICE-1:0] sState;          // Synchronised slice state
	logic [NUM_SLICE-1:0][WORD_W-1:0] sErr;        // Synchronised error codes
	module_pos_t [NUM_SLICE-1:0] sPrim;            // Synchronised primary position
	module_pos_t [NUM_SLICE-1:0] sSec;             // Synchronised secondary position
	logic [NUM_SLICE-1:0] sSwap;                   // Synchronised changeover flags
	logic [OUT_W-1:0] sOut;                        // Synchronised output data
	logic [OUT_W-1:0] sFlt;                        // Synchronised line faults

	// Two flop synchroniser for all slice data
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			syn1_r <= '0;
			syn2_r <= '0;
		end else begin
			syn1_r <= {sliceState, sliceErrCode, primPos, secPos, swapInProgress, outState, lineFault};
			syn2_r <= syn1_r;
		end
	end
	assign {sState, sErr, sPrim, sSec, sSwap, sOut, sFlt} = syn2_r;

	// ************************************************************
	// Two-of-three vote
	// ************************************************************
	function automatic module_pos_t vote(input module_pos_t a, input module_pos_t b, input module_pos_t c);
		vote = module_pos_t'((a & b) | (a & c) | (b & c));
	endfunction

	module_pos_t vPrim;                            // Voted primary position
	module_pos_t vSec;                             // Voted secondary position
	logic        vSwap;                            // Voted changeover flag
	assign vPrim = vote(sPrim[0], sPrim[1], sPrim[2]);
	assign vSec  = vote(sSec[0], sSec[1], sSec[2]);
	assign vSwap = (sSwap[0] & sSwap[1]) | (sSwap[0] & sSwap[2]) | (sSwap[1] & sSwap[2]);

	// ************************************************************
	// Register bus
	// ************************************************************
	logic        swapReq_r;                        // Software changeover request
	logic [7:0]  primCh_r;                         // Configured primary chassis
	logic [7:0]  primSl_r;                         // Configured primary slot
	logic [NUM_EV-1:0] evStat_r;                   // Sticky events
	logic [NUM_EV-1:0] evEn_r;                     // Event enable
	logic [31:0] stamp_r;                          // Free running time base
	logic [31:0] lastStamp_r;                      // Stamp of last change of state
	logic        dWr_r;                            // Data phase is a write
	logic        dRd_r;                            // Data phase is a read
	logic [7:0]  dAddr_r;                          // Data phase address
	logic [NUM_INFO-1:0][WORD_W-1:0] info_r;       // Information channels
	logic [NUM_HK_ERR-1:0][WORD_W-1:0] hkErr_r;    // Diagnostic error words
	logic [NUM_EV-1:0] evSet;                      // Events this cycle
	logic        clrWr;                            // Write to clear register
	logic        aPhase;                           // Valid address phase

	assign aPhase = hsel && hready && htrans[1];
	assign clrWr  = dWr_r && (dAddr_r == ADDR_CLEAR);

	// Capture address phase; the slave is always ready
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			dWr_r   <= 1'b0;
			dRd_r   <= 1'b0;
			dAddr_r <= 8'h00;
		end else begin
			dWr_r   <= aPhase && hwrite;
			dRd_r   <= aPhase && !hwrite;
			dAddr_r <= haddr[7:0];
		end
	end

	// Writable control and enable registers
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			swapReq_r <= 1'b0;
			primCh_r  <= 8'h00;
			primSl_r  <= 8'h00;
			evEn_r    <= '0;
		end else if (dWr_r) begin
			if (dAddr_r == ADDR_CTRL) begin
				swapReq_r <= hwdata[CTRL_SWAP_BIT];
				primCh_r  <= hwdata[CTRL_PCH_LSB +: 8];
				primSl_r  <= hwdata[CTRL_PSL_LSB +: 8];
			end
			if (dAddr_r == ADDR_ENABLE) begin
				evEn_r <= hwdata[NUM_EV-1:0];
			end
		end
	end

	// Read mux, unmapped addresses read zero
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			hrdata <= 32'h0000_0000;
		end else if (aPhase && !hwrite) begin
			hrdata <= 32'h0000_0000;
			case (haddr[7:0])
				ADDR_CTRL:   hrdata <= {8'h00, primSl_r, primCh_r, 7'h00, swapReq_r};
				ADDR_STATUS: hrdata <= {{(32-NUM_EV){1'b0}}, evStat_r};
				ADDR_ENABLE: hrdata <= {{(32-NUM_EV){1'b0}}, evEn_r};
				ADDR_STAMP:  hrdata <= lastStamp_r;
				default: begin
					if (haddr[7:2] >= ADDR_INFO0[7:2] && haddr[7:2] < ADDR_INFO0[7:2] + 6'(NUM_INFO))
						hrdata <= {16'h0000, info_r[haddr[7:2] - ADDR_INFO0[7:2]]};
					else if (haddr[7:2] >= ADDR_HKERR0[7:2] && haddr[7:2] < ADDR_HKERR0[7:2] + 6'(NUM_HK_ERR))
						hrdata <= {{16{hkErr_r[haddr[7:2] - ADDR_HKERR0[7:2]][WORD_W-1]}},
						           hkErr_r[haddr[7:2] - ADDR_HKERR0[7:2]]};
				end
			endcase
		end
	end

	// Bus answers are fixed: no wait states, always OKAY
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	// ************************************************************
	// Housekeeping error words
	// ************************************************************
	genvar gi;
	generate
		for (gi = 0; gi < NUM_HK_ERR; gi++) begin : g_hk
			// Fatal slice reports zero
			always_ff @(posedge sys_clk) begin
				if (!rstn) begin
					hkErr_r[gi] <= '0;
				end else if (sState[gi] == SL_FATAL) begin
					hkErr_r[gi] <= '0;
				end else begin
					hkErr_r[gi] <= sErr[gi];
				end
			end
			a_fatal_zero: assert property (@(posedge sys_clk) disable iff (!rstn)
				sState[gi] == SL_FATAL |=> hkErr_r[gi] == '0) else $error("fatal word not zero");
		end
	endgenerate

	// ************************************************************
	// Information channels
	// ************************************************************
	logic swapped_r;                               // Secondary currently active
	logic swapReqD_r;                              // Delayed request for edge
	logic swapEv;                                  // Changeover happened

	assign swapEv = swapReq_r != swapReqD_r;

	// Changeover state follows the request level
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			swapped_r  <= 1'b0;
			swapReqD_r <= 1'b0;
		end else begin
			swapReqD_r <= swapReq_r;
			swapped_r  <= swapReq_r;
		end
	end

	module_pos_t act;                              // Active position
	module_pos_t sby;                              // Standby position
	assign act = swapped_r ? vSec : vPrim;
	assign sby = swapped_r ? vPrim : vSec;

	function automatic logic [WORD_W-1:0] posNum(input module_pos_t p, input logic useSlot);
		posNum = !p.present ? '0 : {8'h00, useSlot ? p.slot : p.chassis};
	endfunction

	function automatic logic [WORD_W-1:0] modeNum(input module_pos_t p);
		modeNum = (!p.present || p.mode > MODE_SHUTDOWN) ? {13'h0000, MODE_UNKNOWN} : {13'h0000, p.mode};
	endfunction

	// Build the eleven channels
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			info_r <= '0;
		end else begin
			info_r[0]  <= posNum(act, 1'b0);
			info_r[1]  <= posNum(act, 1'b1);
			info_r[2]  <= {15'h0000, act.present & act.healthy};
			info_r[3]  <= modeNum(act);
			info_r[4]  <= posNum(sby, 1'b0);
			info_r[5]  <= posNum(sby, 1'b1);
			info_r[6]  <= {15'h0000, sby.present & sby.healthy};
			info_r[7]  <= modeNum(sby);
			info_r[8]  <= {8'h00, sby.ejectOpen, sby.regionOk, act.ejectOpen, act.regionOk};
			info_r[9]  <= {15'h0000, act.present && act.chassis == primCh_r && act.slot == primSl_r};
			info_r[10] <= {15'h0000, !act.present || act.simEnable};
		end
	end

	a_absent_zero: assert property (@(posedge sys_clk) disable iff (!rstn)
		!act.present |=> info_r[0] == '0 && info_r[1] == '0) else $error("absent position not zero");
	a_upper_byte: assert property (@(posedge sys_clk) disable iff (!rstn)
		info_r[8][15:8] == 8'h00) else $error("status upper byte set");
	a_swap_pos: assert property (@(posedge sys_clk) disable iff (!rstn)
		$rose(swapped_r) && $stable(vPrim) && $stable(vSec) && vSec.present
		|=> info_r[0] == {8'h00, vSec.chassis}) else $error("changeover did not swap");
	a_sim_only: assert property (@(posedge sys_clk) disable iff (!rstn)
		info_r[10] != '0 |-> $past(!act.present || act.simEnable)) else $error("simulated wrongly set");
	a_mode_range: assert property (@(posedge sys_clk) disable iff (!rstn)
		info_r[3] <= 16'(MODE_SHUTDOWN)) else $error("mode code out of range");

	// ************************************************************
	// Change of state events and interrupt
	// ************************************************************
	logic [OUT_W-1:0] prevOut_r;                   // Previous output data
	logic [OUT_W-1:0] prevFlt_r;                   // Previous line faults

	assign evSet = {swapEv, |(sFlt ^ prevFlt_r), |(sOut ^ prevOut_r)};

	// Time base and stamp capture
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			stamp_r     <= 32'h0000_0000;
			lastStamp_r <= 32'h0000_0000;
			prevOut_r   <= '0;
			prevFlt_r   <= '0;
		end else begin
			stamp_r   <= stamp_r + 32'h0000_0001;
			prevOut_r <= sOut;
			prevFlt_r <= sFlt;
			if (evSet[EV_OUT_BIT] || evSet[EV_FLT_BIT])
				lastStamp_r <= stamp_r;
		end
	end

	// Sticky status, set wins over clear
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			evStat_r <= '0;
		end else begin
			evStat_r <= (evStat_r & ~(clrWr ? hwdata[NUM_EV-1:0] : '0)) | evSet;
		end
	end

	// Level interrupt from enabled status
	always_ff @(posedge sys_clk) begin
		if (!rstn) irq <= 1'b0;
		else       irq <= |(evStat_r & evEn_r);
	end

	a_event_stamp: assert property (@(posedge sys_clk) disable iff (!rstn)
		evSet[EV_OUT_BIT] |=> evStat_r[EV_OUT_BIT] && lastStamp_r == $past(stamp_r)) else $error("event not stamped");

	// ************************************************************
	// Flash and amber dividers
	// ************************************************************
	logic [31:0] flashCnt_r;                       // Flash half period counter
	logic        flash_r;                          // Flash phase
	logic [AMBER_DIV_W-1:0] mix_r;                 // Amber mix phase

	// Divider for flashing and colour mixing
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			flashCnt_r <= 32'h0000_0000;
			flash_r    <= 1'b0;
			mix_r      <= '0;
		end else begin
			mix_r <= mix_r + 1'b1;
			if (flashCnt_r == 32'(FLASH_CYCLES - 1)) begin
				flashCnt_r <= 32'h0000_0000;
				flash_r    <= !flash_r;
			end else begin
				flashCnt_r <= flashCnt_r + 32'h0000_0001;
			end
		end
	end

	function automatic led_colour_t shade(input led_colour_t c, input logic fl, input logic fph, input logic mx);
		led_colour_t o;
		o = (fl && !fph) ? LED_OFF : c;
		if (o == LED_AMBER) o = mx ? LED_RED : LED_GREEN;
		shade = o;
	endfunction

	// ************************************************************
	// Indicators
	// ************************************************************
	logic fatalMod;                                // Module fatal by vote
	assign fatalMod = act.mode == MODE_FATAL;

	generate
		for (gi = 0; gi < NUM_SLICE; gi++) begin : g_hl
			// Each slice drives its own health indicator
			always_ff @(posedge sys_clk) begin
				if (!rstn) ledHealthy[gi] <= LED_OFF;
				else case (sState[gi])
					SL_STARTUP: ledHealthy[gi] <= shade(LED_AMBER, 1'b0, flash_r, mix_r[0]);
					SL_HEALTHY: ledHealthy[gi] <= LED_GREEN;
					SL_FAULT:   ledHealthy[gi] <= shade(LED_RED, 1'b1, flash_r, mix_r[0]);
					SL_FATAL:   ledHealthy[gi] <= LED_RED;
					default:    ledHealthy[gi] <= LED_OFF;
				endcase
			end
			a_fatal_red: assert property (@(posedge sys_clk) disable iff (!rstn)
				sState[gi] == SL_FATAL |=> ledHealthy[gi] == LED_RED) else $error("fatal slice not red");
		end
	endgenerate

	// Voted indicators
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			ledActive   <= LED_OFF;
			ledStandby  <= LED_OFF;
			ledEducated <= LED_OFF;
		end else begin
			if (act.mode == MODE_ACTIVE || act.mode == MODE_MAINTAIN)
				ledActive <= LED_GREEN;
			else if (act.mode == MODE_SHUTDOWN || fatalMod)
				ledActive <= shade(LED_RED, 1'b1, flash_r, mix_r[0]);
			else
				ledActive <= LED_OFF;
			if (fatalMod)
				ledStandby <= shade(LED_RED, 1'b1, flash_r, mix_r[0]);
			else if (act.mode == MODE_STANDBY)
				ledStandby <= LED_GREEN;
			else
				ledStandby <= LED_OFF;
			if (vSwap)
				ledEducated <= shade(LED_AMBER, 1'b1, flash_r, mix_r[0]);
			else if (act.educated)
				ledEducated <= LED_GREEN;
			else if (act.recognized)
				ledEducated <= shade(LED_GREEN, 1'b1, flash_r, mix_r[0]);
			else
				ledEducated <= LED_OFF;
		end
	end

	a_active_green: assert property (@(posedge sys_clk) disable iff (!rstn)
		act.mode == MODE_ACTIVE |=> ledActive == LED_GREEN) else $error("active LED not green");
	a_standby_off: assert property (@(posedge sys_clk) disable iff (!rstn)
		act.mode == MODE_ACTIVE |=> ledStandby == LED_OFF) else $error("standby LED lit");

endmodule

// [bench/bus_proc.sv]
`timescale 1ns/1ps

// ************************************************************
// Processor side: single word bus master for status channels
// ************************************************************
module bus_proc (
	input  wire logic        sys_clk,
	input  wire logic        hready,
	input  wire logic [31:0] hrdata,
	output logic             hsel,
	output logic [31:0]      haddr,
	output logic [1:0]       htrans,
	output logic             hwrite,
	output logic [2:0]       hsize,
	output logic [31:0]      hwdata
);
	int hung = 0;                            // Set when the slave never answers

	// Idle bus from time zero
	initial begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
	end

	// One transfer: address phase held until ready, then data phase until ready
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
		int n;
		@(posedge sys_clk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		hsize <= 3'h2;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (hready !== 1'b1 && n < 16);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do begin
			@(posedge sys_clk);
			n++;
		end while (hready !== 1'b1 && n < 32);
		rd = hrdata;
		if (n >= 32) hung = 1;
	endtask
endmodule

// [bench/tb_top.sv]
`timescale 1ns/1ps

// ************************************************************
// Self-checking bench for the status reporter
// ************************************************************
module tb_top;
	import tmr_status_pkg::*;
	logic sys_clk = 1'b0;                    // 50 MHz module clock
	logic rstn = 1'b0;                       // Synchronous reset, active low
	logic hsel, hwrite, hreadyout, hresp, irq;
	logic [31:0] haddr, hwdata, hrdata, d;
	logic [1:0] htrans;
	logic [2:0] hsize;
	slice_state_t [2:0] sliceState = {3{SL_HEALTHY}};
	logic [2:0][15:0] sliceErrCode = '0;
	logic [2:0] swapInProgress = '0;         // Per slice changeover flags
	module_pos_t [2:0] primPos = '0, secPos = '0;
	logic [39:0] outState = '0, lineFault = '0;
	led_colour_t [2:0] ledHealthy;
	led_colour_t ledActive, ledStandby, ledEducated;
	logic [31:0] seed = 32'h0000_0048;       // Xorshift state, fixed start
	int miscompares = 0, nChecks = 0;
	logic [3:0] seen0, seen2;                // Colours seen on fault (flashing) and startup (amber) health LEDs
	logic [3:0] seenA, seenS, seenE;         // Colours seen on voted LEDs
	module_pos_t p, s;

	initial forever #10 sys_clk = ~sys_clk;

	tmr_module_status_reporter #(.FLASH_CYCLES(4)) dut_u (.sys_clk(sys_clk), .rstn(rstn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sliceState(sliceState),
		.sliceErrCode(sliceErrCode), .primPos(primPos), .secPos(secPos), .swapInProgress(swapInProgress),
		.outState(outState), .lineFault(lineFault), .ledHealthy(ledHealthy), .ledActive(ledActive),
		.ledStandby(ledStandby), .ledEducated(ledEducated), .irq(irq));
	bus_proc proc_u (.sys_clk(sys_clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

	// ************************************************************
	// Helpers
	// ************************************************************
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic module_pos_t rpos();
		logic [31:0] r;
		r = xs();
		return '{1'b1, r[7:0], r[15:8], r[16], r[19:17] % 3'h6, r[22:20], r[23], r[24], r[25], r[26]};
	endfunction
	function automatic logic [31:0] z(input logic pr, input logic [7:0] v);
		return pr ? {24'h0, v} : 32'h0;
	endfunction
	task automatic conclude();
		$display("checks %0d mismatches %0d", nChecks, miscompares);
		if (miscompares == 0 && nChecks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
		nChecks++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %0t %s got %h want %h", $time, m, g, e);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v, output logic [31:0] r);
		proc_u.xfer(w, a, v, r);
		if (proc_u.hung != 0) begin
			miscompares++;
			conclude();
		end
	endtask
	// Reads all info channels against the expected active and standby positions
	task automatic infochk(input module_pos_t a, input module_pos_t b, input logic pa);
		logic [31:0] e [11];
		logic [31:0] r;
		e = '{z(a.present, a.chassis), z(a.present, a.slot), {31'h0, a.healthy}, z(a.present, {5'h0, a.mode}),
			z(b.present, b.chassis), z(b.present, b.slot), {31'h0, b.healthy}, z(b.present, {5'h0, b.mode}),
			{24'h0, b.ejectOpen, b.regionOk, a.ejectOpen, a.regionOk}, {31'h0, pa}, {31'h0, !a.present || a.simEnable}};
		for (int i = 0; i < 11; i++) begin
			bus(1'b0, ADDR_INFO0 + 8'(4 * i), 32'h0, r);
			chk(i > 8 ? {31'h0, |r} : r, e[i], "info channel");
		end
	endtask

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial begin
		repeat (4) @(posedge sys_clk);
		chk({29'h0, irq, hreadyout, hresp}, 32'h2, "reset outputs");
		chk({ledHealthy, ledActive, ledStandby, ledEducated}, 32'h0, "reset leds");
		rstn <= 1'b1;
		outState <= {8'h0, xs()};
		repeat (5) @(posedge sys_clk);
		chk(ledHealthy, {3{LED_GREEN}}, "healthy leds");
		for (int k = 0; k < 3; k++) begin
			p = rpos();
			s = rpos();
			s.chassis = p.chassis ^ 8'h01;
			if (k == 2) s = '{present: 1'b0, chassis: 8'h5A, slot: 8'hA5, default: '0};
			primPos <= {rpos(), p, p};
			secPos <= {s, rpos(), s};
			for (int w = 0; w < 2; w++) begin
				bus(1'b1, ADDR_CTRL, {8'h0, p.slot, p.chassis, 7'h0, w[0]}, d);
				repeat (4) @(posedge sys_clk);
				if (w == 1) infochk(s, p, 1'b0);
				else infochk(p, s, 1'b1);
				if (w == 0 && p.mode != MODE_SHUTDOWN)
					chk(ledActive, (p.mode == MODE_ACTIVE || p.mode == MODE_MAINTAIN) ? LED_GREEN : LED_OFF, "act led");
				if (w == 0) chk(ledStandby, (p.mode == MODE_STANDBY) ? LED_GREEN : LED_OFF, "sby led");
				if (w == 0 && (p.educated || !p.recognized))
					chk(ledEducated, p.educated ? LED_GREEN : LED_OFF, "edu led");
			end
		end
		// ************************************************************
		// Change of state events and interrupt
		// ************************************************************
		bus(1'b1, ADDR_CLEAR, 32'h7, d);
		bus(1'b1, ADDR_ENABLE, 32'h1, d);
		lineFault <= ~lineFault;
		repeat (5) @(posedge sys_clk);
		chk({31'h0, irq}, 32'h0, "masked irq");
		outState <= outState ^ 40'h1;
		repeat (5) @(posedge sys_clk);
		chk({31'h0, irq}, 32'h1, "irq");
		bus(1'b1, ADDR_STATUS, 32'h0, d);
		bus(1'b0, ADDR_STATUS, 32'h0, d);
		chk(d, 32'h3, "status");
		bus(1'b1, ADDR_CLEAR, 32'h3, d);
		bus(1'b0, ADDR_STATUS, 32'h0, d);
		chk(d, 32'h0, "cleared");
		repeat (2) @(posedge sys_clk);
		chk({31'h0, irq}, 32'h0, "irq off");
		bus(1'b0, 8'hFC, 32'h0, d);
		chk(d, 32'h0, "unmapped");
		// ************************************************************
		// Diagnostic words and health indicators
		// ************************************************************
		sliceErrCode <= {16'h7FFF, 16'h1234, 16'h8001};
		sliceState <= {SL_STARTUP, SL_FATAL, SL_FAULT};
		// Secondary is active here: make it fatal, and vote a changeover with two slices
		swapInProgress <= 3'h3;
		s = '{present: 1'b1, chassis: 8'h11, slot: 8'h22, mode: MODE_FATAL, default: '0};
		secPos <= {3{s}};
		repeat (5) @(posedge sys_clk);
		bus(1'b0, ADDR_HKERR0, 32'h0, d);
		chk(d, 32'hFFFF8001, "err A");
		bus(1'b0, ADDR_HKERR0 + 8'h4, 32'h0, d);
		chk(d, 32'h0, "err B fatal");
		bus(1'b0, ADDR_HKERR0 + 8'h8, 32'h0, d);
		chk(d, 32'h7FFF, "err C");
		chk(ledHealthy[1], LED_RED, "fatal led");
		seen0 = 4'h0;
		seen2 = 4'h0;
		seenA = 4'h0;
		seenS = 4'h0;
		seenE = 4'h0;
		repeat (10) begin
			@(posedge sys_clk);
			seen0[ledHealthy[0]] = 1'b1;
			seen2[ledHealthy[2]] = 1'b1;
			seenA[ledActive] = 1'b1;
			seenS[ledStandby] = 1'b1;
			seenE[ledEducated] = 1'b1;
		end
		chk(seenA, 4'b0101, "fatal act led");
		chk(seenS, 4'b0101, "fatal sby led");
		chk(seenE, 4'b0111, "changeover edu led");
		chk(seen0, 4'b0101, "fault flash");
		chk(seen2, 4'b0110, "startup amber");
		conclude();
	end
endmodule
